// ===== pcix_cap_consts.vh
`ifndef PCIX_CAP_CONSTS_VH
`define PCIX_CAP_CONSTS_VH

// Register map (byte addresses)
`define CAP_WORD_ADDR      8'h80
`define IRQ_STATUS_ADDR    8'h00
`define IRQ_MASK_ADDR      8'h04
`define MODE_CTRL_ADDR     8'h08

// Capability header fields
`define CAP_ID_VALUE       8'h07
`define CAP_NEXT_VALUE     8'h90

// Status bit positions
`define BIT_WIDE           16
`define BIT_FAST           17
`define BIT_DISCARD        18
`define BIT_UNEXP          19
`define BIT_OVERRUN        20
`define BIT_DELAYED        21
`define FREQ_LO            22
`define FREQ_HI            24

// Byte lanes and interrupt field
`define LANE_STATUS        2
`define LANE_LOW           0
`define IRQ_BIT_HI         3
`define IRQ_BIT_LO         0

// Clock frequency codes
`define FREQ_CONV          3'h0
`define FREQ_66            3'h1
`define FREQ_133           3'h2

// AXI responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ===== pcix_secondary_status_capability.v
// Function
// - Low byte of capability word reads constant 07h.
// - Bits 15:8 read 90h, the next capability link, read-only.
// - Bit 16 is strap value in forward mode, zero in reverse mode.
// - Bit 17 reads one in forward mode, zero in reverse, read-only.
// - Bit 18 sets on discarded split completion, forward mode only; resets zero.
// - Bit 19 sets on unexpected completion matching own ID, reverse only.
// - Bit 20 sets when incoming completion terminated for full buffer.
// - Bit 21 sets when split request delayed by commitment limit.
// - Bits 24:22 report secondary clock code in forward mode.
// - Clock code reads zero in reverse mode, resets zero, read-only.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "pcix_cap_consts.vh"

//------------------------------------------------------------
// Register map
//------------------------------------------------------------
// 0x80  capability word: id, link, secondary status
//       bits 21:18 write-one-to-clear on byte lane 2
//       bits 31:25 reserved, read zero
// 0x00  interrupt status, same four events, bits 3:0
//       write-one-to-clear on byte lane 0
// 0x04  interrupt mask, bits 3:0, a set bit masks
// 0x08  bridge mode, bit 0 high in reverse mode, read-only
// Other addresses answer SLVERR, read data zero
//
// Bus timing
// Ready one cycle after valid, one transfer at a time
// Write response one cycle after both halves held
// Read data one cycle after the address handshake
// Status visible one cycle after the event, irq one later

module pcix_secondary_status_capability (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire        reverse_mode,
    input  wire        wide_secondary_strap,
    input  wire [2:0]  sec_clk_code,
    input  wire        ev_split_discard,
    input  wire        ev_unexpected_cpl,
    input  wire        ev_cpl_overrun,
    input  wire        ev_req_delayed,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         irq
);

    //------------------------------------------------------------
    // State
    //------------------------------------------------------------
    reg  [3:0]  sticky_r;      // discard, unexp, overrun, delayed
    reg  [3:0]  irq_mask_r;
    reg  [2:0]  freq_r;
    reg         wide_r;
    reg         fast_r;
    reg  [7:0]  aw_addr_r;
    reg         aw_have_r;
    reg  [31:0] w_data_r;
    reg  [3:0]  w_strb_r;
    reg         w_have_r;

    wire [3:0]  events;
    wire [3:0]  clr_w1c;
    wire [3:0]  clr_irq;
    wire        wr_fire;
    wire [31:0] cap_word;

    //------------------------------------------------------------
    // Helper functions
    //------------------------------------------------------------
    // Register select by exact byte address
    function addr_hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    // Registers that answer OKAY; mode word only on reads
    function addr_mapped;
        input [7:0] addr;
        input       is_read;
        begin
            addr_mapped = addr_hit(addr, `CAP_WORD_ADDR) |
                          addr_hit(addr, `IRQ_STATUS_ADDR) |
                          addr_hit(addr, `IRQ_MASK_ADDR) |
                          (is_read & addr_hit(addr, `MODE_CTRL_ADDR));
        end
    endfunction

    // Response code for a mapped or unmapped access
    function [1:0] resp_code;
        input mapped;
        begin
            resp_code = mapped ? `RESP_OKAY : `RESP_SLVERR;
        end
    endfunction

    // Bits to clear from one written lane
    function [3:0] w1c_bits;
        input       hit;
        input       lane_en;
        input [3:0] ones;
        begin
            w1c_bits = (hit && lane_en) ? ones : 4'h0;
        end
    endfunction

    // Read data of a mapped register, zero elsewhere
    function [31:0] read_mux;
        input [7:0]  addr;
        input [31:0] cap;
        input [3:0]  status;
        input [3:0]  mask;
        input        mode;
        begin
            case (addr)
                `CAP_WORD_ADDR:   read_mux = cap;
                `IRQ_STATUS_ADDR: read_mux = {28'h000_0000, status};
                `IRQ_MASK_ADDR:   read_mux = {28'h000_0000, mask};
                `MODE_CTRL_ADDR:  read_mux = {31'h0000_0000, mode};
                default:          read_mux = 32'h0000_0000;
            endcase
        end
    endfunction

    //------------------------------------------------------------
    // Event qualification by bridge mode
    //------------------------------------------------------------
    assign events = {ev_req_delayed,
                     ev_cpl_overrun,
                     ev_unexpected_cpl & reverse_mode,
                     ev_split_discard & ~reverse_mode};

    assign wr_fire = aw_have_r & w_have_r & ~s_axi_bvalid;

    // Write-one-to-clear decode: byte lane 2 at 0x80, byte lane 0 at 0x00
    assign clr_w1c = w1c_bits(wr_fire & addr_hit(aw_addr_r, `CAP_WORD_ADDR),
                              w_strb_r[`LANE_STATUS], w_data_r[`BIT_DELAYED:`BIT_DISCARD]);
    assign clr_irq = w1c_bits(wr_fire & addr_hit(aw_addr_r, `IRQ_STATUS_ADDR),
                              w_strb_r[`LANE_LOW], w_data_r[`IRQ_BIT_HI:`IRQ_BIT_LO]);

    // Composed capability word, reserved bits zero
    assign cap_word = {7'h00, freq_r, sticky_r, fast_r, wide_r,
                       `CAP_NEXT_VALUE,
                       `CAP_ID_VALUE};

    //------------------------------------------------------------
    // Status fields, qualified by bridge mode
    //------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            sticky_r <= 4'h0;
        end else begin
            // Set wins over clear
            sticky_r <= (sticky_r & ~(clr_w1c | clr_irq)) | events;
            // Discard bit held at zero in reverse mode
            if (reverse_mode)
                sticky_r[0] <= 1'b0;
            // Unexpected-completion bit held at zero in forward mode
            if (!reverse_mode)
                sticky_r[1] <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // Strap and mode-dependent read-only fields
    //------------------------------------------------------------
    // Follow strap, mode and clock code every cycle
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            freq_r <= `FREQ_CONV;
            wide_r <= 1'b0;
            fast_r <= 1'b0;
        end else begin
            wide_r <= wide_secondary_strap & ~reverse_mode;
            fast_r <= ~reverse_mode;
            freq_r <= reverse_mode ? `FREQ_CONV : sec_clk_code;
        end
    end

    //------------------------------------------------------------
    // AXI4-Lite write channel
    //------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            aw_addr_r     <= 8'h00;
            w_data_r      <= 32'h0000_0000;
            w_strb_r      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            // Ready pulses once per offered item
            s_axi_awready <= ~aw_have_r & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_have_r & ~s_axi_wready & s_axi_wvalid;
            // Address held until the response
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            // Data and strobes held until the response
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            // Both halves consumed by the response
            if (wr_fire) begin
                aw_have_r <= 1'b0;
                w_have_r  <= 1'b0;
            end
        end
    end

    //------------------------------------------------------------
    // AXI4-Lite write response
    //------------------------------------------------------------
    // Answer once both halves are held; unmapped gets SLVERR
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= resp_code(addr_mapped(aw_addr_r, 1'b0));
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // Interrupt mask register
    //------------------------------------------------------------
    // A set bit keeps its status bit off the interrupt line
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_mask_r <= 4'h0;
        end else if (wr_fire && addr_hit(aw_addr_r, `IRQ_MASK_ADDR) && w_strb_r[`LANE_LOW]) begin
            irq_mask_r <= w_data_r[`IRQ_BIT_HI:`IRQ_BIT_LO];
        end
    end

    //------------------------------------------------------------
    // AXI4-Lite read channel
    //------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            // Address taken once, never while data is pending
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                // Data and code chosen from the address
                s_axi_rresp  <= resp_code(addr_mapped(s_axi_araddr, 1'b1));
                s_axi_rdata  <= read_mux(s_axi_araddr, cap_word, sticky_r, irq_mask_r, reverse_mode);
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    //------------------------------------------------------------
    // Interrupt output
    //------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!rst_n)
            irq <= 1'b0;
        else
            // High while any unmasked status bit is set
            irq <= |(sticky_r & ~irq_mask_r);
    end

endmodule

`default_nettype wire

// ===== pcix_far_side.sv
`timescale 1ns/1ps
`default_nettype none
// -----------------------------
// Secondary bus event source
// -----------------------------
module pcix_far_side (
    input  wire logic       clk_sys,
    input  wire logic [3:0] fire,
    output var  logic [3:0] ev
);
    // One-cycle event pulses: discard, unexpected, overrun, delayed
    always @(posedge clk_sys) begin
        ev <= fire;
    end
endmodule
`default_nettype wire

// ===== pcix_cap_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcix_cap_consts.vh"
module pcix_cap_chk (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        reverse_mode,
    input wire logic        wide_secondary_strap,
    input wire logic [2:0]  sec_clk_code,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready
);
    logic [7:0] ra_r;
    wire  logic cap = s_axi_rvalid && ra_r == `CAP_WORD_ADDR;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Address of the read under way
    always @(posedge clk_sys) begin
        if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
    end
    a_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_cap_header: assert property (cap |-> s_axi_rdata[15:0] == 16'h9007)
        else $error("bad capability header");
    a_reserved_zero: assert property (cap |-> s_axi_rdata[31:25] == 7'h00)
        else $error("reserved bits set");
    a_rev_zero: assert property (cap && reverse_mode |-> (s_axi_rdata & 32'h01c70000) == 32'h0)
        else $error("reverse mode bits set");
    a_fwd_caps: assert property (cap && !reverse_mode |-> s_axi_rdata[17:16] == {1'h1, wide_secondary_strap})
        else $error("forward width or speed wrong");
    a_fwd_clock: assert property (cap && !reverse_mode |-> s_axi_rdata[24:22] == sec_clk_code)
        else $error("clock code wrong");
endmodule
bind pcix_secondary_status_capability pcix_cap_chk u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .reverse_mode(reverse_mode),
    .wide_secondary_strap(wide_secondary_strap), .sec_clk_code(sec_clk_code),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcix_cap_consts.vh"
module tb_top;
    logic        clk_sys = 0, rst_n = 0, reverse_mode = 0, wide_secondary_strap = 1, irq;
    logic [2:0]  sec_clk_code = `FREQ_133;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = '0, fire = '0, ev;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs, ws;
    int          n_mismatch = 0, total_checks = 0, cyc = 0;
    always #5 clk_sys = ~clk_sys;
    pcix_secondary_status_capability uut (
        .clk_sys(clk_sys), .rst_n(rst_n), .reverse_mode(reverse_mode),
        .wide_secondary_strap(wide_secondary_strap), .sec_clk_code(sec_clk_code),
        .ev_split_discard(ev[0]), .ev_unexpected_cpl(ev[1]), .ev_cpl_overrun(ev[2]), .ev_req_delayed(ev[3]),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));
    pcix_far_side far (.clk_sys(clk_sys), .fire(fire), .ev(ev));
    // ----------------
    // Tasks
    // ----------------
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_sys);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, s, 3'h7};
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        ws = s_axi_bresp;
        s_axi_bready <= 1'h0;
        repeat (2) @(posedge clk_sys);
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'h0;
        chk(rd, e);
    endtask
    task fire_ev(input logic [3:0] f);
        @(posedge clk_sys);
        fire <= f;
        @(posedge clk_sys);
        fire <= 4'h0;
        repeat (3) @(posedge clk_sys);
    endtask
    // Hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            finish_test;
        end
    end
    // ----------------
    // Test sequence
    // ----------------
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'h1;
        rchk(8'h80, 32'h00839007);
        chk(rs, `RESP_OKAY);
        $display("test 1 done");
        fire_ev(4'hf);
        rchk(8'h80, 32'h00b79007);
        rchk(8'h00, 32'h0000000d);
        wr(8'h04, 32'h0, 4'h1);
        chk(irq, 32'h1);
        wr(8'h04, 32'hf, 4'h1);
        chk(irq, 32'h0);
        wr(8'h04, 32'h0, 4'h1);
        wr(8'h80, 32'h00100000, 4'h4);
        chk(ws, `RESP_OKAY);
        wr(8'h80, 32'hfeffffff, 4'hb);
        rchk(8'h80, 32'h00a79007);
        wr(8'h80, 32'h00ff0000, 4'h4);
        rchk(8'h80, 32'h00839007);
        chk(irq, 32'h0);
        wide_secondary_strap <= 1'h0;
        sec_clk_code <= `FREQ_66;
        rchk(8'h80, 32'h00429007);
        sec_clk_code <= `FREQ_CONV;
        rchk(8'h80, 32'h00029007);
        wr(8'h40, 32'hffffffff, 4'hf);
        chk(ws, `RESP_SLVERR);
        $display("test 2 done");
        reverse_mode <= 1'h1;
        fire_ev(4'hf);
        rchk(8'h80, 32'h00389007);
        rchk(8'h08, 32'h1);
        wr(8'h00, 32'hf, 4'h1);
        rchk(8'h80, 32'h00009007);
        rchk(8'h40, 32'h0);
        chk(rs, `RESP_SLVERR);
        $display("test 3 done");
        finish_test;
    end
endmodule
`default_nettype wire
